//--- hw/rcap_top.sv
`timescale 1ns/1ps
module rcap_top
  import rcap_pkg::*;
#(
  parameter logic P_ROOT_FLUSH = 1'b1,
  parameter logic P_INTR_FLUSH = 1'b1,
  parameter logic P_ECMD = 1'b0,
  parameter logic P_FS_SUPPORT = 1'b1,
  parameter logic P_FS5 = 1'b1,
  parameter logic P_FS1G = 1'b1,
  parameter logic P_IR = 1'b1,
  parameter logic P_PI = 1'b1,
  parameter logic P_PSI = 1'b1,
  parameter logic P_SCALABLE_MODE_SUPPORT = 1'b1,
  parameter logic [5:0] P_MAX_ADDRESS_MASK_VALUE = 6'h12,
  parameter int unsigned P_FAULT_REGS = 8,
  parameter logic [3:0] P_VER_MAJOR = 4'h2,
  parameter logic [3:0] P_VER_MINOR = 4'h0
) (
  input logic clk_i,
  input logic rst_i,
  input logic psel_i,
  input logic penable_i,
  input logic pwrite_i,
  input logic [11:0] paddr_i,
  input logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input logic inv_valid_i,
  input rcap_inv_req_t inv_req_i,
  output logic inv_ready_o,
  output logic inv_done_o,
  output logic inv_ok_o,
  input logic drain_ack_i,
  output logic drain_rd_o,
  output logic drain_wr_o
);
  localparam rcap_feat_t FEAT = '{
    root_flush: P_ROOT_FLUSH,
    intr_flush: P_INTR_FLUSH,
    ecmd: P_ECMD,
    fs_support: P_FS_SUPPORT,
    fs5: P_FS5,
    fs1g: P_FS1G,
    ir: P_IR,
    pi: P_PI,
    max_address_mask_value: P_MAX_ADDRESS_MASK_VALUE,
    fault_register_count: rcap_nfr_field(P_FAULT_REGS),
    page_selective_flush_support: P_PSI
  };

  // Capability is fixed by the build, so it folds to constants in synthesis
  localparam logic [63:0] CAP_WORD = rcap_build_cap(FEAT);

  localparam logic [31:0] VER_WORD = {24'h0, P_VER_MAJOR, P_VER_MINOR};

  typedef enum logic [1:0] {INV_IDLE, INV_CHECK, INV_DRAIN} rcap_inv_state_t;

  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic setup;

  rcap_inv_state_t inv_state_r, inv_state_nxt;
  logic inv_ready_r, inv_ready_nxt;
  logic inv_done_r, inv_done_nxt;
  logic inv_ok_r, inv_ok_nxt;
  logic inv_take;
  logic drn_start;
  logic chk_valid, chk_ok, chk_rd, chk_wr;
  logic drn_done;

  // APB slave with no wait states: the answer comes in the first access cycle
  always_comb begin
    setup = psel_i && !penable_i;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup) begin
      pready_nxt = 1'b1;
      case (paddr_i)
        ADDR_VERSION: begin
          if (!pwrite_i) begin
            prdata_nxt = VER_WORD;
          end
        end
        ADDR_CAP_LO: begin
          if (!pwrite_i) begin
            prdata_nxt = CAP_WORD[31:0];
          end
        end
        ADDR_CAP_HI: begin
          if (!pwrite_i) begin
            prdata_nxt = CAP_WORD[63:32];
          end
        end
        default: begin
          pslverr_nxt = 1'b1;
          if (!pwrite_i) begin
            prdata_nxt = PRDATA_RST;
          end
        end
      endcase
      // Writes to mapped words complete cleanly but change nothing
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_r <= PRDATA_RST;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;

  // Invalidation sequencing; one request in flight keeps ordering simple
  always_comb begin
    inv_take = inv_valid_i && inv_ready_r;
    inv_state_nxt = inv_state_r;
    inv_done_nxt = 1'b0;
    inv_ok_nxt = inv_ok_r;
    drn_start = 1'b0;
    case (inv_state_r)
      INV_IDLE: begin
        if (inv_take) begin
          inv_state_nxt = INV_CHECK;
        end
      end
      INV_CHECK: begin
        if (chk_valid) begin
          if (chk_ok && (chk_rd || chk_wr)) begin
            drn_start = 1'b1;
            inv_state_nxt = INV_DRAIN;
          end else begin
            inv_done_nxt = 1'b1;
            inv_ok_nxt = chk_ok;
            inv_state_nxt = INV_IDLE;
          end
        end
      end
      INV_DRAIN: begin
        if (drn_done) begin
          inv_done_nxt = 1'b1;
          inv_ok_nxt = 1'b1;
          inv_state_nxt = INV_IDLE;
        end
      end
      default: inv_state_nxt = INV_IDLE;
    endcase
    inv_ready_nxt = (inv_state_nxt == INV_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inv_state_r <= INV_IDLE;
      inv_ready_r <= 1'b0;
      inv_done_r <= 1'b0;
      inv_ok_r <= 1'b0;
    end else begin
      inv_state_r <= inv_state_nxt;
      inv_ready_r <= inv_ready_nxt;
      inv_done_r <= inv_done_nxt;
      inv_ok_r <= inv_ok_nxt;
    end
  end

  assign inv_ready_o = inv_ready_r;
  assign inv_done_o = inv_done_r;
  assign inv_ok_o = inv_ok_r;

  rcap_inv_check u_check (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_valid_i(inv_take),
    .req_i(inv_req_i),
    .psi_i(FEAT.page_selective_flush_support),
    .scalable_mode_support_i(P_SCALABLE_MODE_SUPPORT),
    .max_address_mask_value_i(FEAT.max_address_mask_value),
    .major_i(P_VER_MAJOR),
    .chk_valid_o(chk_valid),
    .chk_ok_o(chk_ok),
    .chk_rd_o(chk_rd),
    .chk_wr_o(chk_wr)
  );

  rcap_drain u_drain (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(drn_start),
    .rd_i(chk_rd),
    .wr_i(chk_wr),
    .ack_i(drain_ack_i),
    .drain_rd_o(drain_rd_o),
    .drain_wr_o(drain_wr_o),
    .done_o(drn_done)
  );

  a_cap_lo_read: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_LO
    |=> pready_o && !pslverr_o && prdata_o == CAP_WORD[31:0])
    else $error("capability low word wrong");

  a_cap_hi_read: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI
    |=> pready_o && prdata_o == CAP_WORD[63:32] ##1 !pready_o)
    else $error("capability high word wrong");

  a_fs_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI && !P_FS_SUPPORT
    |=> prdata_o[BIT_FS5-HI_BASE] == 1'b0 && prdata_o[BIT_FS1G-HI_BASE] == 1'b0)
    else $error("first-stage bits set without support");

  a_pi_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI && !P_IR
    |=> prdata_o[BIT_PI-HI_BASE] == 1'b0)
    else $error("posted interrupts without remapping");

  a_drain_ones: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI
    |=> prdata_o[BIT_RD_DRAIN-HI_BASE] && prdata_o[BIT_WR_DRAIN-HI_BASE])
    else $error("drain bits not one");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI
    |=> prdata_o[26:25] == 2'b00 && prdata_o[6] == 1'b0)
    else $error("reserved capability bits set");

  a_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && pwrite_i |=> $stable(prdata_o) && pready_o)
    else $error("write disturbed read data");

  a_nfr_range: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI
    |=> 32'(prdata_o[NFR_LSB-HI_BASE +: 8]) + 32'd1 == ((P_FAULT_REGS > MAX_FAULT_REGS) ?
    MAX_FAULT_REGS : ((P_FAULT_REGS < 1) ? 1 : P_FAULT_REGS)))
    else $error("fault register count wrong");

  a_max_address_mask_value_floor: assert property (@(posedge clk_i) disable iff (rst_i)
    P_PSI |-> P_MAX_ADDRESS_MASK_VALUE >= MAX_ADDRESS_MASK_VALUE_REC)
    else $error("mask limit below recommendation");

  a_version_major: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_VERSION
    |=> prdata_o[VER_MAJOR_LSB +: 4] == P_VER_MAJOR)
    else $error("major version wrong");

  a_unmapped_err: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && paddr_i != ADDR_VERSION && paddr_i != ADDR_CAP_LO && paddr_i != ADDR_CAP_HI
    |=> pready_o && pslverr_o)
    else $error("unmapped address not flagged");

  a_drain_before_done: assert property (@(posedge clk_i) disable iff (rst_i)
    inv_take && P_VER_MAJOR >= DRAIN_MAJOR && inv_req_i.kind != INV_PAGE
    && inv_req_i.kind != INV_PASID_ADDR ##2 1'b1 |-> drain_rd_o && drain_wr_o)
    else $error("automatic drain missing");

  a_page_over_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    inv_take && inv_req_i.kind == INV_PAGE && inv_req_i.mask > P_MAX_ADDRESS_MASK_VALUE
    |-> ##2 inv_done_o && !inv_ok_o)
    else $error("oversize mask accepted");

  a_refused_no_drain: assert property (@(posedge clk_i) disable iff (rst_i)
    inv_take && inv_req_i.kind == INV_PAGE && inv_req_i.mask > P_MAX_ADDRESS_MASK_VALUE
    |-> ##2 !drain_rd_o && !drain_wr_o)
    else $error("refused flush drained");

  a_page_needs_psi: assert property (@(posedge clk_i) disable iff (rst_i)
    inv_take && inv_req_i.kind == INV_PAGE && !P_PSI
    |-> ##2 inv_done_o && !inv_ok_o)
    else $error("page flush accepted without support");

  // Field checks use the parameters directly, so a packing slip cannot hide
  a_root_flush_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI
    |=> prdata_o[BIT_ROOT_FLUSH-HI_BASE] == P_ROOT_FLUSH)
    else $error("root flush bit wrong");

  a_intr_flush_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI
    |=> prdata_o[BIT_INTR_FLUSH-HI_BASE] == P_INTR_FLUSH)
    else $error("interrupt flush bit wrong");

  a_ecmd_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI
    |=> prdata_o[BIT_ECMD-HI_BASE] == P_ECMD)
    else $error("enhanced command bit wrong");

  a_fs5_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI
    |=> prdata_o[BIT_FS5-HI_BASE] == (P_FS5 & P_FS_SUPPORT))
    else $error("five-level bit wrong");

  a_pi_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI
    |=> prdata_o[BIT_PI-HI_BASE] == (P_PI & P_IR))
    else $error("posted interrupt bit wrong");

  a_fs1g_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI
    |=> prdata_o[BIT_FS1G-HI_BASE] == (P_FS1G & P_FS_SUPPORT))
    else $error("gigabyte page bit wrong");

  a_max_address_mask_value_field: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI
    |=> prdata_o[MAX_ADDRESS_MASK_VALUE_LSB-HI_BASE +: 6] == P_MAX_ADDRESS_MASK_VALUE)
    else $error("mask limit field wrong");

  a_psi_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_CAP_HI
    |=> prdata_o[BIT_PSI-HI_BASE] == P_PSI)
    else $error("page flush bit wrong");

  a_version_rest: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && paddr_i == ADDR_VERSION
    |=> prdata_o[3:0] == P_VER_MINOR && prdata_o[31:8] == 24'h0)
    else $error("version word wrong");
endmodule

//--- hw/rcap_pkg.sv
package rcap_pkg;
  localparam logic [11:0] ADDR_VERSION = 12'h000;
  localparam logic [11:0] ADDR_CAP_LO = 12'h008;
  localparam logic [11:0] ADDR_CAP_HI = 12'h00c;
  localparam int BIT_ROOT_FLUSH = 63;
  localparam int BIT_INTR_FLUSH = 62;
  localparam int BIT_ECMD = 61;
  localparam int BIT_FS5 = 60;
  localparam int BIT_PI = 59;
  localparam int BIT_FS1G = 56;
  localparam int BIT_RD_DRAIN = 55;
  localparam int BIT_WR_DRAIN = 54;
  localparam int MAX_ADDRESS_MASK_VALUE_LSB = 48;
  localparam int NFR_LSB = 40;
  localparam int BIT_PSI = 39;
  localparam int VER_MAJOR_LSB = 4;
  localparam int HI_BASE = 32;
  localparam int MAX_FAULT_REGS = 256;
  localparam logic [3:0] DRAIN_MAJOR = 4'h2;
  localparam logic [5:0] MAX_ADDRESS_MASK_VALUE_REC = 6'h09;
  localparam logic [5:0] MAX_ADDRESS_MASK_VALUE_REC_GB = 6'h12;
  localparam logic [31:0] PRDATA_RST = 32'h0;

  typedef struct packed {
    logic root_flush;
    logic intr_flush;
    logic ecmd;
    logic fs_support;
    logic fs5;
    logic fs1g;
    logic ir;
    logic pi;
    logic [5:0] max_address_mask_value;
    logic [7:0] fault_register_count;
    logic page_selective_flush_support;
  } rcap_feat_t;

  typedef enum logic [1:0] {INV_GLOBAL, INV_DOMAIN, INV_PAGE, INV_PASID_ADDR} rcap_inv_kind_t;

  typedef struct packed {
    rcap_inv_kind_t kind;
    logic [5:0] mask;
    logic drain_rd;
    logic drain_wr;
  } rcap_inv_req_t;

  // Count of fault records clamped to 1..256, reported as count minus one
  function automatic logic [7:0] rcap_nfr_field(int unsigned count);
    int unsigned c;
    c = count;
    if (c < 1) c = 1;
    if (c > MAX_FAULT_REGS) c = MAX_FAULT_REGS;
    return 8'(c - 1);
  endfunction

  function automatic logic [63:0] rcap_build_cap(rcap_feat_t f);
    logic [63:0] c;
    c = 64'h0;
    c[BIT_ROOT_FLUSH] = f.root_flush;
    c[BIT_INTR_FLUSH] = f.intr_flush;
    c[BIT_ECMD] = f.ecmd;
    c[BIT_FS5] = f.fs5 & f.fs_support;
    c[BIT_PI] = f.pi & f.ir;
    c[BIT_FS1G] = f.fs1g & f.fs_support;
    c[BIT_RD_DRAIN] = 1'b1;
    c[BIT_WR_DRAIN] = 1'b1;
    c[MAX_ADDRESS_MASK_VALUE_LSB +: 6] = f.max_address_mask_value;
    c[NFR_LSB +: 8] = f.fault_register_count;
    c[BIT_PSI] = f.page_selective_flush_support;
    return c;
  endfunction
endpackage

//--- hw/rcap_inv_check.sv
`timescale 1ns/1ps
module rcap_inv_check
  import rcap_pkg::*;
(
  input logic clk_i,
  input logic rst_i,
  input logic req_valid_i,
  input rcap_inv_req_t req_i,
  input logic psi_i,
  input logic scalable_mode_support_i,
  input logic [5:0] max_address_mask_value_i,
  input logic [3:0] major_i,
  output logic chk_valid_o,
  output logic chk_ok_o,
  output logic chk_rd_o,
  output logic chk_wr_o
);
  logic valid_r, valid_nxt, ok_r, ok_nxt, rd_r, rd_nxt, wr_r, wr_nxt;
  logic auto_drain;

  always_comb begin
    auto_drain = (major_i >= DRAIN_MAJOR);
    valid_nxt = req_valid_i;
    ok_nxt = ok_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    if (req_valid_i) begin
      case (req_i.kind)
        INV_PAGE: ok_nxt = psi_i && (req_i.mask <= max_address_mask_value_i);
        INV_PASID_ADDR: ok_nxt = scalable_mode_support_i;
        default: ok_nxt = 1'b1;
      endcase
      rd_nxt = auto_drain | req_i.drain_rd;
      wr_nxt = auto_drain | req_i.drain_wr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_r <= 1'b0;
      ok_r <= 1'b0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
      ok_r <= ok_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
    end
  end

  assign chk_valid_o = valid_r;
  assign chk_ok_o = ok_r;
  assign chk_rd_o = rd_r;
  assign chk_wr_o = wr_r;

  a_pasid_any_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    req_valid_i && req_i.kind == INV_PASID_ADDR && scalable_mode_support_i |=> chk_valid_o && chk_ok_o)
    else $error("pasid invalidation refused");
  a_auto_drain: assert property (@(posedge clk_i) disable iff (rst_i)
    req_valid_i && major_i >= DRAIN_MAJOR |=> chk_rd_o && chk_wr_o)
    else $error("drain not forced");
endmodule

//--- hw/rcap_drain.sv
`timescale 1ns/1ps
module rcap_drain
  import rcap_pkg::*;
(
  input logic clk_i,
  input logic rst_i,
  input logic start_i,
  input logic rd_i,
  input logic wr_i,
  input logic ack_i,
  output logic drain_rd_o,
  output logic drain_wr_o,
  output logic done_o
);
  typedef enum logic {DRN_IDLE, DRN_WAIT} rcap_drn_state_t;
  rcap_drn_state_t state_r, state_nxt;
  logic rd_r, rd_nxt, wr_r, wr_nxt, done_r, done_nxt;

  always_comb begin
    state_nxt = state_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    done_nxt = 1'b0;
    case (state_r)
      DRN_IDLE: begin
        if (start_i) begin
          rd_nxt = rd_i;
          wr_nxt = wr_i;
          state_nxt = DRN_WAIT;
        end
      end
      DRN_WAIT: begin
        // Levels hold until the datapath reports outstanding traffic gone
        if (ack_i) begin
          rd_nxt = 1'b0;
          wr_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = DRN_IDLE;
        end
      end
      default: state_nxt = DRN_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= DRN_IDLE;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      done_r <= done_nxt;
    end
  end

  assign drain_rd_o = rd_r;
  assign drain_wr_o = wr_r;
  assign done_o = done_r;
endmodule

//--- verification/remap_capability_register_test.sv
`timescale 1ns/1ps
module remap_capability_register_test
  import rcap_pkg::*;
;
  logic clk_i;
  logic rst_i;
  logic psel [2];
  logic penable [2];
  logic pwrite [2];
  logic [11:0] paddr [2];
  logic [31:0] pwdata [2];
  logic [31:0] prdata [2];
  logic pready [2];
  logic pslverr [2];
  logic inv_valid [2];
  rcap_inv_req_t inv_req [2];
  logic inv_ready [2];
  logic inv_done [2];
  logic inv_ok [2];
  logic drain_ack [2];
  logic drain_rd [2];
  logic drain_wr [2];
  int n_mismatch;
  int n_checks;

  // Unit 0 has all but enhanced command; unit 1 has enhanced command, lacks root and interrupt flush, first stage, remapping, page flush, scalable mode
  for (genvar g = 0; g < 2; g++) begin : u_g
    rcap_top #(
      .P_ROOT_FLUSH(g == 0),
      .P_INTR_FLUSH(g == 0),
      .P_ECMD(g == 1),
      .P_FS_SUPPORT(g == 0),
      .P_IR(g == 0),
      .P_PSI(g == 0),
      .P_SCALABLE_MODE_SUPPORT(g == 0),
      .P_MAX_ADDRESS_MASK_VALUE(g ? 6'h09 : 6'h12),
      .P_FAULT_REGS(g ? 256 : 8),
      .P_VER_MAJOR(g ? 4'h1 : 4'h2)
    ) rcap_top_inst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .psel_i(psel[g]),
      .penable_i(penable[g]),
      .pwrite_i(pwrite[g]),
      .paddr_i(paddr[g]),
      .pwdata_i(pwdata[g]),
      .prdata_o(prdata[g]),
      .pready_o(pready[g]),
      .pslverr_o(pslverr[g]),
      .inv_valid_i(inv_valid[g]),
      .inv_req_i(inv_req[g]),
      .inv_ready_o(inv_ready[g]),
      .inv_done_o(inv_done[g]),
      .inv_ok_o(inv_ok[g]),
      .drain_ack_i(drain_ack[g]),
      .drain_rd_o(drain_rd[g]),
      .drain_wr_o(drain_wr[g])
    );
  end

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready without assuming its latency
  task automatic apb(input int u, input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk_i);
    psel[u] <= 1'b1;
    penable[u] <= 1'b0;
    pwrite[u] <= wr;
    paddr[u] <= a;
    pwdata[u] <= wd;
    @(posedge clk_i);
    penable[u] <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (pready[u] !== 1'b1 && i < 20);
    rd = prdata[u];
    err = pslverr[u];
    psel[u] <= 1'b0;
    penable[u] <= 1'b0;
    if (i >= 20) check(32'h0, 32'h1);
  endtask

  task automatic rd_chk(input int u, input logic [11:0] a, input logic [31:0] exp,
                        input logic eerr);
    logic [31:0] d;
    logic e;
    apb(u, 1'b0, a, 32'h0, d, e);
    check(d, exp);
    check(e, eerr);
  endtask

  // Drain ack is withheld a few cycles so the drain request must stand
  task automatic inv(input int u, input rcap_inv_kind_t k, input logic [5:0] m,
                     input logic dr, input logic dw, input logic eok, input logic erd,
                     input logic ewr);
    int i;
    int c;
    logic srd;
    logic swr;
    logic ackd;
    srd = 1'b0;
    ackd = 1'b0;
    swr = 1'b0;
    c = 0;
    @(posedge clk_i);
    inv_valid[u] <= 1'b1;
    inv_req[u] <= '{kind: k, mask: m, drain_rd: dr, drain_wr: dw};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (inv_ready[u] !== 1'b1 && i < 20);
    inv_valid[u] <= 1'b0;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
      if (drain_rd[u] === 1'b1) srd = 1'b1;
      if (drain_wr[u] === 1'b1) swr = 1'b1;
      if (srd | swr) c++;
      // Ack stands until the design has sampled it once, then drops
      if (drain_ack[u] === 1'b1) ackd = 1'b1;
      drain_ack[u] <= (c >= 3) && !ackd;
    end while (inv_done[u] !== 1'b1 && i < 60);
    if (i >= 60) check(32'h0, 32'h1);
    check(inv_ok[u], eok);
    check(srd, erd);
    check(swr, ewr);
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    complete_run();
  end

  initial begin
    logic [31:0] d;
    logic [31:0] h;
    logic e;
    n_mismatch = 0;
    n_checks = 0;
    rst_i = 1'b1;
    for (int u = 0; u < 2; u++) begin
      psel[u] = 1'b0;
      penable[u] = 1'b0;
      pwrite[u] = 1'b0;
      paddr[u] = 12'h000;
      pwdata[u] = 32'h0;
      inv_valid[u] = 1'b0;
      inv_req[u] = '0;
      drain_ack[u] = 1'b0;
    end
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    check(prdata[0], 32'h0);
    // Full-feature word: bits 63,62,60,59,56,55,54, mask 18, seven, bit 39
    rd_chk(0, ADDR_CAP_LO, 32'h0, 1'b0);
    rd_chk(0, ADDR_CAP_HI, 32'hd9d20780, 1'b0);
    rd_chk(0, ADDR_VERSION, 32'h00000020, 1'b0);
    rd_chk(0, 12'h010, 32'h0, 1'b1);
    apb(0, 1'b1, ADDR_CAP_HI, 32'hffffffff, d, e);
    check(e, 1'b0);
    apb(0, 1'b1, ADDR_CAP_LO, 32'hffffffff, d, e);
    check(e, 1'b0);
    rd_chk(0, ADDR_CAP_HI, 32'hd9d20780, 1'b0);
    rd_chk(0, ADDR_CAP_LO, 32'h0, 1'b0);
    // Software view: mask only with page flush, count plus one, fault offset
    apb(0, 1'b0, ADDR_CAP_HI, 32'h0, h, e);
    apb(0, 1'b0, ADDR_CAP_LO, 32'h0, d, e);
    check(h[BIT_PSI-HI_BASE] ? 32'(h[MAX_ADDRESS_MASK_VALUE_LSB-HI_BASE +: 6]) : 32'h0, 32'h12);
    check(32'(h[NFR_LSB-HI_BASE +: 8]) + 32'd1, 32'd8);
    check(32'({h[1:0], d[31:24]}) * 32'd16, 32'h0);
    // Reduced word: enhanced command only, both drains, mask 9, count field 255
    rd_chk(1, ADDR_CAP_HI, 32'h20c9ff00, 1'b0);
    rd_chk(1, ADDR_CAP_HI, 32'h20c9ff00, 1'b0);
    rd_chk(1, ADDR_CAP_HI, 32'h20c9ff00, 1'b0);
    rd_chk(1, ADDR_VERSION, 32'h00000010, 1'b0);
    apb(1, 1'b0, ADDR_CAP_HI, 32'h0, h, e);
    check(32'(h[NFR_LSB-HI_BASE +: 8]) + 32'd1, 32'd256);
    // Major version two drains on every accepted flush, asked or not
    inv(0, INV_GLOBAL, 6'h00, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    inv(0, INV_DOMAIN, 6'h00, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    inv(0, INV_PAGE, 6'h12, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    inv(0, INV_PAGE, 6'h13, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    inv(0, INV_PASID_ADDR, 6'h3f, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    // Older major version follows the request bits
    inv(1, INV_PAGE, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    inv(1, INV_PASID_ADDR, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    inv(1, INV_GLOBAL, 6'h00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    inv(1, INV_DOMAIN, 6'h00, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    inv(1, INV_GLOBAL, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    rd_chk(1, 12'hffc, 32'h0, 1'b1);
    complete_run();
  end
endmodule
